// ### hw/sps_config_top.sv
// How it works
// - sync input pulse resets the filter path and reloads the configuration registers from the pins in pin mode, from the serial-mode registers in serial mode.
// - asynchronous start pulse is re-timed and driven on the sync output.
// - toggling bit 0 of setup register two in serial mode pulses sync output.
// - filter notch at maximum rate, 16 or 8 kHz, plus two at output rate.
// - both layout select pins high means serial control, else pin control.
// - pin layout codes give four, two or one lanes; aux select uses serial port.
// - four strap pins set power mode, decimation, channels 4-7 gain and reference.
// - codes 0000-0011 high resolution, external, unity, decimation 1024 down to 128.
// - codes 0100-0111 channels 4-7 gain 2,4,4,4, decimation 256,512,256,128.
// - codes 1000-1010 high resolution, internal reference, decimation 512,256,128.
// - codes 1011-1111 low power with the listed references and decimations.
// - output rate is 2048 or 512 ksps divided by decimation.
// - three clock select pins give output clock divide of two to the n.
// - all configuration pins are re-sampled on every sync input pulse.
// - pin mode disables rate converter, diagnostics and serial result readout.
// - serial mode output layout comes from registers 0x013 and 0x014.
// - serial mode readout enable lets results be read over serial port.
// - channel phase delay is captured only on a sync input pulse.
// - modulator clock is master clock divided by 4 or by 8.
module sps_config_top
	import sps_pkg::*;
#(
	parameter int NUM_CH  = 8,
	parameter int PHASE_W = 8
) (
	// clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_n_i,
	// synchronisation pins
	input  wire logic                      sync_in_n_i,
	input  wire logic                      start_n_i,
	output logic                           sync_out_n_o,
	// strap and format pins
	input  wire logic                      config_strap_0_i,
	input  wire logic                      config_strap_1_i,
	input  wire logic                      config_strap_2_i,
	input  wire logic                      config_strap_3_i,
	input  wire logic                      output_layout_sel_0_i,
	input  wire logic                      output_layout_sel_1_i,
	input  wire logic                      aux_converter_select_i,
	input  wire logic                      out_clk_div_sel_0_i,
	input  wire logic                      out_clk_div_sel_1_i,
	input  wire logic                      out_clk_div_sel_2_i,
	// serial-mode register contents
	input  wire logic                      general_user_setup_two_i,
	input  wire logic [7:0]                out_if_setup_a_i,
	input  wire logic [7:0]                out_if_setup_b_i,
	input  wire logic                      serial_result_readout_enable_i,
	input  wire logic                      rate_converter_enable_i,
	input  wire logic                      diagnostics_enable_i,
	input  wire logic                      sw_low_power_i,
	input  wire logic                      sw_int_ref_i,
	input  wire logic [3:0]                sw_dec_log2_i,
	input  wire logic [3:0]                sw_gain_grp0_i,
	input  wire logic [3:0]                sw_gain_grp1_i,
	input  wire logic [2:0]                sw_clk_div_log2_i,
	input  wire logic [NUM_CH*PHASE_W-1:0] channel_phase_delay_i,
	// filter path control
	output logic                           filter_reset_o,
	output logic                           config_valid_o,
	output logic                           modulator_clock_o,
	output logic                           data_shift_clock_tick_o,
	// applied configuration
	output logic                           serial_mode_o,
	output logic                           low_power_o,
	output logic                           int_ref_o,
	output logic [11:0]                    decimation_o,
	output logic [11:0]                    output_sample_rate_o,
	output logic [11:0]                    max_rate_o,
	output logic [3:0]                     gain_grp0_o,
	output logic [3:0]                     gain_grp1_o,
	output logic [2:0]                     clk_div_log2_o,
	output logic [3:0]                     lane_enable_o,
	output logic [3:0]                     chans_per_lane_o,
	output logic                           serial_port_output_o,
	output logic [15:0]                    out_if_setup_o,
	output logic                           rate_converter_en_o,
	output logic                           diagnostics_en_o,
	output logic                           readout_en_o,
	output logic [NUM_CH*PHASE_W-1:0]      channel_phase_delay_o
);

	localparam int PIN_W = 10;

	initial begin
		if (NUM_CH != 8 || PHASE_W < 1 || PHASE_W > 16) begin
			$error("sps_config_top: unsupported channel count or phase width");
		end
	end

	// all static pins gathered into one vector for the synchroniser
	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] pins_meta;
	logic [PIN_W-1:0] pins_sync;
	logic             sin_meta;
	logic             sin_sync;
	logic             sin_prev;
	logic             sync_fall;

	assign pins_raw = {out_clk_div_sel_2_i, out_clk_div_sel_1_i, out_clk_div_sel_0_i,
		aux_converter_select_i, output_layout_sel_1_i, output_layout_sel_0_i,
		config_strap_3_i, config_strap_2_i, config_strap_1_i, config_strap_0_i};

	// two-flop synchronisers for sync input and strap pins
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sin_meta  <= 1'b1;
			sin_sync  <= 1'b1;
			pins_meta <= '0;
			pins_sync <= '0;
		end else begin
			sin_meta  <= sync_in_n_i;
			sin_sync  <= sin_meta;
			pins_meta <= pins_raw;
			pins_sync <= pins_meta;
		end
	end

	// sync pulse generator for the start pin and software bit
	sps_sync_if sif ();

	assign sif.start_n     = start_n_i;
	assign sif.serial_mode = serial_mode_o;
	assign sif.sw_sync_bit = general_user_setup_two_i;

	sps_sync_gen u_gen (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.sif     (sif)
	);

	assign sync_out_n_o = sif.sync_out_n;

	// start-up sequence and sync edge detection
	sps_state_t state;
	sps_state_t next_state;
	logic [1:0] settle_cnt;
	logic [1:0] next_settle_cnt;
	logic       next_sin_prev;
	logic       next_filter_reset;
	logic       capture;

	always_comb begin
		next_state        = state;
		next_settle_cnt   = settle_cnt;
		next_sin_prev     = sin_sync;
		sync_fall         = sin_prev & ~sin_sync;
		capture           = 1'b0;
		next_filter_reset = sync_fall;
		case (state)
			SPS_ST_RESET: begin
				next_state      = SPS_ST_SETTLE;
				next_settle_cnt = '0;
			end
			SPS_ST_SETTLE: begin
				next_settle_cnt = settle_cnt + 2'h1;
				if (settle_cnt == SETTLE_CYCLES) begin
					next_state = SPS_ST_RUN;
					capture    = 1'b1; // power-up strap sampling
				end
			end
			SPS_ST_RUN: begin
				capture = sync_fall;
			end
			default: begin
				next_state = SPS_ST_RESET;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state          <= SPS_ST_RESET;
			settle_cnt     <= '0;
			sin_prev       <= 1'b1;
			filter_reset_o <= 1'b0;
		end else begin
			state          <= next_state;
			settle_cnt     <= next_settle_cnt;
			sin_prev       <= next_sin_prev;
			filter_reset_o <= next_filter_reset;
		end
	end

	// decode of the sampled pins into the next applied configuration
	sps_strap_entry_t entry;
	logic       pin_serial;
	logic       next_serial;
	logic       next_lp;
	logic       next_iref;
	logic [3:0] next_dec_log2;
	logic [3:0] dec_log2;
	logic [3:0] next_gain0;
	logic [3:0] next_gain1;
	logic [2:0] next_div;
	logic [3:0] next_lanes;
	logic [3:0] next_cpl;
	logic       next_spi_out;
	logic [15:0] next_if_setup;
	logic       next_valid;

	always_comb begin
		entry         = STRAP_TABLE[pins_sync[3:0]];
		pin_serial    = (pins_sync[5:4] == SERIAL_FORMAT_CODE);
		next_serial   = serial_mode_o;
		next_lp       = low_power_o;
		next_iref     = int_ref_o;
		next_dec_log2 = dec_log2;
		next_gain0    = gain_grp0_o;
		next_gain1    = gain_grp1_o;
		next_div      = clk_div_log2_o;
		next_lanes    = lane_enable_o;
		next_cpl      = chans_per_lane_o;
		next_spi_out  = serial_port_output_o;
		next_if_setup = out_if_setup_o;
		next_valid    = config_valid_o | capture;
		if (capture) begin
			next_serial = pin_serial;
			if (pin_serial) begin
				// register-driven setup takes effect on the sync pulse
				next_lp       = sw_low_power_i;
				next_iref     = sw_int_ref_i;
				next_dec_log2 = (sw_dec_log2_i > DEC_LOG2_MAX) ? DEC_LOG2_MAX : sw_dec_log2_i;
				next_gain0    = sw_gain_grp0_i;
				next_gain1    = sw_gain_grp1_i;
				next_div      = sw_clk_div_log2_i;
				next_lanes    = '0;
				next_cpl      = '0;
				next_spi_out  = 1'b0;
				next_if_setup = {out_if_setup_b_i, out_if_setup_a_i};
			end else begin
				next_lp       = entry[ST_LP_BIT];
				next_iref     = entry[ST_IREF_BIT];
				next_dec_log2 = entry[ST_DEC_HI:ST_DEC_LO];
				next_gain0    = GAIN_UNITY;
				next_gain1    = entry[ST_GAIN_HI:ST_GAIN_LO];
				next_div      = pins_sync[9:7];
				next_spi_out  = pins_sync[6];
				next_if_setup = '0;
				case (pins_sync[5:4])
					LAYOUT_FOUR_LANES: begin
						next_lanes = LANES_FOUR;
						next_cpl   = CPL_FOUR;
					end
					LAYOUT_TWO_LANES: begin
						next_lanes = LANES_TWO;
						next_cpl   = CPL_TWO;
					end
					LAYOUT_ONE_LANE: begin
						next_lanes = LANES_ONE;
						next_cpl   = CPL_ONE;
					end
					default: begin
						next_lanes = '0;
						next_cpl   = '0;
					end
				endcase
				if (pins_sync[6]) begin
					next_lanes = '0; // results leave over the serial port
				end
			end
		end
	end

	// applied configuration registers, changed only on a capture

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			serial_mode_o        <= 1'b0;
			low_power_o          <= 1'b0;
			int_ref_o            <= 1'b0;
			dec_log2             <= RST_DEC_LOG2;
			gain_grp0_o          <= GAIN_UNITY;
			gain_grp1_o          <= GAIN_UNITY;
			clk_div_log2_o       <= '0;
			lane_enable_o        <= '0;
			chans_per_lane_o     <= '0;
			serial_port_output_o <= 1'b0;
			out_if_setup_o       <= '0;
			config_valid_o       <= 1'b0;
		end else begin
			serial_mode_o        <= next_serial;
			low_power_o          <= next_lp;
			int_ref_o            <= next_iref;
			dec_log2             <= next_dec_log2;
			gain_grp0_o          <= next_gain0;
			gain_grp1_o          <= next_gain1;
			clk_div_log2_o       <= next_div;
			lane_enable_o        <= next_lanes;
			chans_per_lane_o     <= next_cpl;
			serial_port_output_o <= next_spi_out;
			out_if_setup_o       <= next_if_setup;
			config_valid_o       <= next_valid;
		end
	end

	// derived rates and mode-gated feature enables
	logic [11:0] next_decimation;
	logic [11:0] next_rate;
	logic [11:0] next_max_rate;
	logic        next_src_en;
	logic        next_diag_en;
	logic        next_readout_en;

	always_comb begin
		next_decimation = 12'h001 << dec_log2;
		next_rate       = (low_power_o ? LP_BASE_KSPS : HR_BASE_KSPS) >> dec_log2;
		next_max_rate   = low_power_o ? LP_MAX_KSPS : HR_MAX_KSPS;
		next_src_en     = serial_mode_o & rate_converter_enable_i;
		next_diag_en    = serial_mode_o & diagnostics_enable_i;
		next_readout_en = serial_mode_o & serial_result_readout_enable_i;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			decimation_o         <= '0;
			output_sample_rate_o <= '0;
			max_rate_o           <= '0;
			rate_converter_en_o  <= 1'b0;
			diagnostics_en_o     <= 1'b0;
			readout_en_o         <= 1'b0;
		end else begin
			decimation_o         <= next_decimation;
			output_sample_rate_o <= next_rate;
			max_rate_o           <= next_max_rate;
			rate_converter_en_o  <= next_src_en;
			diagnostics_en_o     <= next_diag_en;
			readout_en_o         <= next_readout_en;
		end
	end

	// modulator and output clock dividers, restarted by the filter reset
	logic [MOD_CNT_W-1:0]   mod_cnt;
	logic [MOD_CNT_W-1:0]   next_mod_cnt;
	logic                   next_mod_clk;
	logic [SHIFT_CNT_W-1:0] shift_cnt;
	logic [SHIFT_CNT_W-1:0] next_shift_cnt;
	logic [SHIFT_CNT_W-1:0] shift_mask;
	logic                   next_tick;

	always_comb begin
		next_mod_cnt   = filter_reset_o ? '0 : mod_cnt + {{(MOD_CNT_W-1){1'b0}}, 1'b1};
		next_mod_clk   = low_power_o ? next_mod_cnt[LP_MOD_DIV_LOG2-1]
			: next_mod_cnt[HR_MOD_DIV_LOG2-1];
		shift_mask     = ~({SHIFT_CNT_W{1'b1}} << clk_div_log2_o);
		next_shift_cnt = filter_reset_o ? '0 : shift_cnt + {{(SHIFT_CNT_W-1){1'b0}}, 1'b1};
		next_tick      = ((shift_cnt & shift_mask) == shift_mask) & ~filter_reset_o;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mod_cnt                 <= '0;
			modulator_clock_o       <= 1'b0;
			shift_cnt               <= '0;
			data_shift_clock_tick_o <= 1'b0;
		end else begin
			mod_cnt                 <= next_mod_cnt;
			modulator_clock_o       <= next_mod_clk;
			shift_cnt               <= next_shift_cnt;
			data_shift_clock_tick_o <= next_tick;
		end
	end

	// per-channel phase delay, latched only on a sync input pulse
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_phase
			logic [PHASE_W-1:0] phase;
			logic [PHASE_W-1:0] next_phase;

			always_comb begin
				next_phase = phase;
				if (sync_fall) begin
					next_phase = channel_phase_delay_i[ch*PHASE_W +: PHASE_W];
				end
			end

			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					phase <= '0;
				end else begin
					phase <= next_phase;
				end
			end

			assign channel_phase_delay_o[ch*PHASE_W +: PHASE_W] = phase;
		end
	endgenerate

endmodule

// ### hw/sps_pkg.sv
package sps_pkg;

	// control mode selection: both layout select pins high means serial control
	localparam logic [1:0] SERIAL_FORMAT_CODE = 2'h3;
	localparam logic [1:0] LAYOUT_FOUR_LANES  = 2'h0;
	localparam logic [1:0] LAYOUT_TWO_LANES   = 2'h1;
	localparam logic [1:0] LAYOUT_ONE_LANE    = 2'h2;

	// lane enables and channels per lane for each pin layout
	localparam logic [3:0] LANES_FOUR   = 4'hF;
	localparam logic [3:0] LANES_TWO    = 4'h3;
	localparam logic [3:0] LANES_ONE    = 4'h1;
	localparam logic [3:0] CPL_FOUR     = 4'h2;
	localparam logic [3:0] CPL_TWO      = 4'h4;
	localparam logic [3:0] CPL_ONE      = 4'h8;

	// serial-mode output interface setup register addresses
	localparam logic [11:0] OUT_IF_SETUP_A_ADDR = 12'h013;
	localparam logic [11:0] OUT_IF_SETUP_B_ADDR = 12'h014;

	// bit of the second general setup register that fires a sync pulse
	localparam int SW_SYNC_BIT = 0;

	// modulator clock dividers: by 4 high resolution, by 8 low power
	localparam int HR_MOD_DIV_LOG2 = 2;
	localparam int LP_MOD_DIV_LOG2 = 3;
	localparam int MOD_CNT_W       = 3;

	// output rate numerators in ksps (2048 and 512) and maximum rates (16, 8)
	localparam logic [11:0] HR_BASE_KSPS = 12'h800;
	localparam logic [11:0] LP_BASE_KSPS = 12'h200;
	localparam logic [11:0] HR_MAX_KSPS  = 12'h010;
	localparam logic [11:0] LP_MAX_KSPS  = 12'h008;

	// largest decimation exponent the 12-bit decimation output holds
	localparam logic [3:0] DEC_LOG2_MAX = 4'hB;

	// output clock divider: exponent 0..7, divide by 1..128
	localparam int SHIFT_CNT_W = 7;

	// pins settle through the synchroniser for this many cycles before first capture
	localparam logic [1:0] SETTLE_CYCLES = 2'h2;

	// reset values of the applied configuration
	localparam logic [3:0] GAIN_UNITY   = 4'h1;
	localparam logic [3:0] RST_DEC_LOG2 = 4'hA;

	// strap table entry layout
	localparam int ST_LP_BIT   = 9;
	localparam int ST_IREF_BIT = 8;
	localparam int ST_GAIN_HI  = 7;
	localparam int ST_GAIN_LO  = 4;
	localparam int ST_DEC_HI   = 3;
	localparam int ST_DEC_LO   = 0;

	typedef logic [9:0] sps_strap_entry_t;

	// {low power, internal ref, gain ch4-7, log2 decimation} per strap code
	localparam sps_strap_entry_t STRAP_TABLE [16] = '{
		10'h01A, 10'h019, 10'h018, 10'h017,
		10'h028, 10'h049, 10'h048, 10'h047,
		10'h119, 10'h118, 10'h117, 10'h219,
		10'h218, 10'h217, 10'h317, 10'h318
	};

	// start-up sequence of the configuration loader
	typedef enum logic [1:0] {
		SPS_ST_RESET  = 2'h0,
		SPS_ST_SETTLE = 2'h1,
		SPS_ST_RUN    = 2'h3
	} sps_state_t;

endpackage

// ### hw/sps_sync_if.sv
interface sps_sync_if;
	logic start_n;
	logic serial_mode;
	logic sw_sync_bit;
	logic sync_out_n;
	logic start_seen;

	modport gen (
		input  start_n,
		input  serial_mode,
		input  sw_sync_bit,
		output sync_out_n,
		output start_seen
	);

	modport ctl (
		output start_n,
		output serial_mode,
		output sw_sync_bit,
		input  sync_out_n,
		input  start_seen
	);
endinterface

// ### hw/sps_sync_gen.sv
module sps_sync_gen
	import sps_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// link to the configuration loader
	sps_sync_if.gen  sif
);

	logic start_meta;
	logic start_sync;
	logic start_prev;
	logic sw_prev;
	logic armed;
	logic sync_out_n;
	logic start_seen;
	logic next_start_prev;
	logic next_sw_prev;
	logic next_armed;
	logic next_sync_out_n;
	logic next_start_seen;
	logic start_fall;
	logic sw_toggle;

	// start pin synchroniser, first stage read only by the second
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_meta <= 1'b1;
			start_sync <= 1'b1;
		end else begin
			start_meta <= sif.start_n;
			start_sync <= start_meta;
		end
	end

	// pulse generation from start falling edge or software bit toggle
	always_comb begin
		start_fall      = start_prev & ~start_sync;
		sw_toggle       = armed & sif.serial_mode & (sw_prev ^ sif.sw_sync_bit);
		next_start_prev = start_sync;
		next_sw_prev    = sif.sw_sync_bit;
		next_armed      = 1'b1; // first cycle only learns the bit level
		next_sync_out_n = ~(start_fall | sw_toggle);
		next_start_seen = start_fall;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_prev <= 1'b1;
			sw_prev    <= 1'b0;
			armed      <= 1'b0;
			sync_out_n <= 1'b1;
			start_seen <= 1'b0;
		end else begin
			start_prev <= next_start_prev;
			sw_prev    <= next_sw_prev;
			armed      <= next_armed;
			sync_out_n <= next_sync_out_n;
			start_seen <= next_start_seen;
		end
	end

	assign sif.sync_out_n = sync_out_n;
	assign sif.start_seen = start_seen;

endmodule

// ### sim/sps_checker.sv
module sps_checker (
	// clock, reset and pins
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        sync_in_n_i,
	input wire logic        start_n_i,
	input wire logic        output_layout_sel_0_i,
	input wire logic        output_layout_sel_1_i,
	input wire logic        general_user_setup_two_i,
	// watched outputs
	input wire logic        sync_out_n_o,
	input wire logic        filter_reset_o,
	input wire logic        config_valid_o,
	input wire logic        serial_mode_o,
	input wire logic        low_power_o,
	input wire logic        rate_converter_en_o,
	input wire logic        diagnostics_en_o,
	input wire logic        readout_en_o,
	input wire logic [11:0] decimation_o,
	input wire logic [11:0] output_sample_rate_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// generated sync lasts one cycle
	a_sync_one_cycle: assert property ($fell(sync_out_n_o) |=> sync_out_n_o)
		else $error("sync output low for more than one cycle");
	// start fall re-timed onto the sync output
	a_start_to_sync: assert property ($fell(start_n_i) |-> ##[2:4] !sync_out_n_o)
		else $error("start fall gave no sync output pulse");
	// filter reset is a single pulse
	a_filter_pulse_one: assert property (filter_reset_o |=> !filter_reset_o)
		else $error("filter reset longer than one cycle");
	// sync input fall resets the filter path
	a_sync_in_reset: assert property ($fell(sync_in_n_i) |-> ##[2:4] filter_reset_o)
		else $error("sync input fall gave no filter reset");
	// control mode taken from both layout pins at capture
	a_serial_decode: assert property (filter_reset_o && config_valid_o |->
		serial_mode_o == (output_layout_sel_0_i && output_layout_sel_1_i))
		else $error("control mode decode wrong");
	// pin mode keeps extended functions off
	a_pin_mode_off: assert property (!serial_mode_o && !$past(serial_mode_o) |->
		!rate_converter_en_o && !diagnostics_en_o && !readout_en_o)
		else $error("extended function enabled in pin mode");
	// software bit toggle in serial mode fires sync output
	a_sw_toggle: assert property (serial_mode_o && $stable(serial_mode_o) && $changed(general_user_setup_two_i)
		|-> ##[1:2] !sync_out_n_o)
		else $error("software toggle gave no sync output pulse");
	// output rate times decimation equals the mode base rate
	a_rate_relation: assert property (config_valid_o && $past(config_valid_o) && !filter_reset_o |->
		24'(output_sample_rate_o) * 24'(decimation_o) == (low_power_o ? 24'h200 : 24'h800))
		else $error("output rate does not match decimation");
endmodule

bind sps_config_top sps_checker u_sps_checker (.*);

// ### sim/sps_host_model.sv
module sps_host_model (
	// clock and loop-back selection
	input  wire logic clk_i,
	input  wire logic loop_en_i,
	input  wire logic sync_out_n_i,
	// pins driven into the device
	output logic      sync_in_n_o,
	output logic      start_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic own_n;
	// internal sync: sync output wired back to sync input
	assign sync_in_n_o = loop_en_i ? sync_out_n_i : own_n;
	// start held high while unused
	initial begin
		own_n = 1'b1;
		start_n_o = 1'b1;
	end
	// low three cycles then high three, launched on the falling clock edge
	task automatic pulse(input bit on_start);
		for (int i = 0; i < 6; i++) begin
			@(negedge clk_i);
			if (on_start) start_n_o = (i > 2);
			else own_n = (i > 2);
		end
	endtask
endmodule

// ### sim/testbench.sv
module testbench;
	import sps_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// stimulus
	logic        clk, rst_n, sync_in_n, start_n, loop_en, sw_bit, en, sw_lp, sw_iref, aux;
	logic [3:0]  strap, sw_dec, sw_g0, sw_g1;
	logic [1:0]  layout;
	logic [2:0]  div;
	logic [7:0]  if_a, if_b;
	logic [63:0] phase;
	// design outputs
	logic        sync_out_n, frst, valid, mclk, tick, ser, lp, iref, sport, src, diag, ro;
	logic [11:0] dec, rate, maxr;
	logic [3:0]  g0, g1, lanes, cpl;
	logic [2:0]  cdiv;
	logic [15:0] ifs;
	logic [63:0] ph_o;
	int          n_fail, tests_run, cycles, n_sout, n_frst, nt, nm, e_lp, k;
	bit          mprev;
	int          dec_t [16] = '{1024,512,256,128,256,512,256,128,512,256,128,512,256,128,128,256};
	int          g1_t [16] = '{1,1,1,1,2,4,4,4,1,1,1,1,1,1,1,1};

	sps_config_top u_sps_config_top (.clk_i(clk), .rst_n_i(rst_n), .sync_in_n_i(sync_in_n), .start_n_i(start_n),
		.sync_out_n_o(sync_out_n), .config_strap_0_i(strap[0]), .config_strap_1_i(strap[1]),
		.config_strap_2_i(strap[2]), .config_strap_3_i(strap[3]), .output_layout_sel_0_i(layout[0]),
		.output_layout_sel_1_i(layout[1]), .aux_converter_select_i(aux), .out_clk_div_sel_0_i(div[0]),
		.out_clk_div_sel_1_i(div[1]), .out_clk_div_sel_2_i(div[2]), .general_user_setup_two_i(sw_bit),
		.out_if_setup_a_i(if_a), .out_if_setup_b_i(if_b), .serial_result_readout_enable_i(en),
		.rate_converter_enable_i(en), .diagnostics_enable_i(en), .sw_low_power_i(sw_lp), .sw_int_ref_i(sw_iref),
		.sw_dec_log2_i(sw_dec), .sw_gain_grp0_i(sw_g0), .sw_gain_grp1_i(sw_g1), .sw_clk_div_log2_i(div),
		.channel_phase_delay_i(phase), .filter_reset_o(frst), .config_valid_o(valid), .modulator_clock_o(mclk),
		.data_shift_clock_tick_o(tick), .serial_mode_o(ser), .low_power_o(lp), .int_ref_o(iref),
		.decimation_o(dec), .output_sample_rate_o(rate), .max_rate_o(maxr), .gain_grp0_o(g0), .gain_grp1_o(g1),
		.clk_div_log2_o(cdiv), .lane_enable_o(lanes), .chans_per_lane_o(cpl), .serial_port_output_o(sport),
		.out_if_setup_o(ifs), .rate_converter_en_o(src), .diagnostics_en_o(diag), .readout_en_o(ro),
		.channel_phase_delay_o(ph_o));
	sps_host_model u_sps_host_model (.clk_i(clk), .loop_en_i(loop_en), .sync_out_n_i(sync_out_n),
		.sync_in_n_o(sync_in_n), .start_n_o(start_n));

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	always #5 clk = ~clk;
	// counts sync pulses and filter resets mid-cycle where they are settled, cuts a hang short
	always @(negedge clk) begin
		n_sout += !sync_out_n;
		n_frst += frst;
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			summarize();
		end
	end

	initial begin
		k = $urandom(47);
		{clk, rst_n, loop_en, sw_bit, en, sw_lp, sw_iref, aux, strap, layout, div} = '0;
		{sw_dec, sw_g0, sw_g1, if_a, if_b, phase} = '0;
		repeat (4) @(negedge clk);
		check(sync_out_n, 1);
		check(valid, 0);
		rst_n = 1;
		// every strap code with random layout, divider and phase
		for (int c = 0; c < 16; c++) begin
			@(negedge clk);
			strap = 4'(c);
			layout = 2'($urandom_range(0, 2));
			aux = 1'($urandom_range(0, 1));
			div = 3'($urandom);
			phase = {$urandom, $urandom};
			en = 1;
			u_sps_host_model.pulse(0);
			repeat (2) @(negedge clk);
			e_lp = (c >= 11);
			check(lp, e_lp);
			check(iref, c inside {[8:10], 14, 15});
			check(dec, dec_t[c]);
			check(g0, 1);
			check(g1, g1_t[c]);
			check(rate, (e_lp ? 512 : 2048) / dec_t[c]);
			check(maxr, e_lp ? 8 : 16);
			check(cdiv, div);
			check({ser, src, diag, ro}, 0);
			check(lanes, aux ? 0 : layout == 0 ? 'hF : layout == 1 ? 3 : 1);
			check(sport, aux);
			if (!aux) check(cpl, 2 << layout);
			check(ph_o, phase);
			phase = ~phase;
			{nt, nm} = '0;
			mprev = mclk; // count edges over exactly 256 intervals
			repeat (256) begin
				@(negedge clk);
				nt += tick;
				nm += (mclk && !mprev);
				mprev = mclk;
			end
			check(ph_o, ~phase);
			check(nt, 256 >> div);
			check(nm, e_lp ? 32 : 64);
		end
		$display("strap table test done");
		// start pin re-timed, looped back to the sync input
		{k, nt} = {n_sout, n_frst};
		loop_en = 1;
		u_sps_host_model.pulse(1);
		repeat (6) @(negedge clk);
		check(n_sout - k, 1);
		check(n_frst - nt, 1);
		loop_en = 0;
		$display("start pin test done");
		// serial control mode from the software settings
		layout = 2'h3;
		sw_lp = 1'($urandom);
		sw_iref = 1'($urandom);
		sw_dec = 4'($urandom_range(7, 9));
		sw_g0 = 4'($urandom);
		sw_g1 = 4'($urandom);
		{if_a, if_b} = 16'($urandom);
		u_sps_host_model.pulse(0);
		repeat (2) @(negedge clk);
		check({ser, lp, iref, lanes, cdiv}, {1'b1, sw_lp, sw_iref, 4'h0, div});
		check({g0, g1}, {sw_g0, sw_g1});
		check(dec, 1 << sw_dec);
		check(ifs, {if_b, if_a});
		check({src, diag, ro}, 3'h7);
		en = 0;
		@(negedge clk);
		@(negedge clk);
		check({src, diag, ro}, 3'h0);
		for (int m = 0; m < 2; m++) begin
			k = n_sout;
			repeat (4) begin
				sw_bit = ~sw_bit;
				repeat (2) @(negedge clk);
			end
			check(n_sout - k, m ? 0 : 4);
			layout = 2'h0;
			u_sps_host_model.pulse(0);
		end
		$display("serial mode test done");
		// reset in mid-run restarts the power-up capture
		rst_n = 0;
		@(negedge clk);
		check({valid, sync_out_n}, 1);
		rst_n = 1;
		repeat (10) @(negedge clk);
		check({valid, ser}, 2);
		check(dec, dec_t[strap]);
		$display("second reset test done");
		summarize();
	end
endmodule
